// ### dcra_pkg.sv
// Purpose: shared constants for the eight-channel dual-address transfer engine
// Assumes: one clock (mclk), asynchronous active-high reset
// Notes:   field positions refer to the per-channel control words fed in as ports
//
// Contract
// [RL1] Internal request asks core for bus; cycles start only after grant.
// [RL2] Control bit 11 picks snoop or non-snoop bus acquisition per channel.
// [RL3] Bit 10 set in non-snoop mode: give bus back on core request.
// [RL4] Release bus once no channel has a pending request.
// [RL5] NMI held pending while the engine owns the bus.
// [RL6] Software stops engine before halting core or entering doze with snoop.
// [RL7] Start with external select 0 raises internal request at once.
// [RL8] Internal request stays until channel ends; units run back to back.
// [RL9] Internally requested channels move memory to memory only.
// [RL10] Start with external select 1 waits in standby for a request.
// [RL11] Interrupt-router request by low level; pin by falling edge or level.
// [RL12] Dual address only: read into holding buffer, then write out.
// [RL13] Acknowledge strobe asserts on every I/O access of the channel.
// [RL14] Eight channels 0..7; writing start 1 puts channel in standby.
// [RL15] Standby: request transfers, none releases bus, completion/error goes idle.
// [RL16] Completion of a channel raises an interrupt signal.
// [RL17] Source and destination each increment, decrement or stay fixed.
// [RL18] Software sets address change to fixed on the I/O side.
// [RL19] Counting start bit selectable per side: 0, 4, 8, 12 or 16.
// [RL20] Unit moved per request is 32, 16 or 8 bits.
// [RL21] Step is 2**bit above zero, else the unit in bytes.
// [RL22] Count selects 3 bits: 000..100 valid, 101..111 prohibited.
// [RL23] Router request cleared by ack; memory-to-memory acks only at count zero.
// [RL24] Pin: memory-to-memory uses level only, I/O-to-memory falling edge only.

package dcra_pkg;
  localparam int NCH = 8;
  localparam int AW = 32;
  localparam int CCR_W = 16;
  localparam int DTCR_W = 6;
  // Channel control word
  localparam int CCR_SNOOP = 11;
  localparam int CCR_YIELD = 10;
  localparam int CCR_EXT = 9;
  localparam int CCR_SAC_LO = 6;
  localparam int CCR_DAC_LO = 4;
  localparam int CCR_SIZE_LO = 2;
  localparam int CCR_SRC_IO = 1;
  localparam int CCR_DST_IO = 0;
  // Transfer control word
  localparam int DTCR_SOURCE_COUNT_BIT_SEL_LO = 0;
  localparam int DTCR_DEST_COUNT_BIT_SEL_LO = 3;
  // Address change codes; 1x means fixed
  localparam logic [1:0] CHG_INC = 2'h0;
  localparam logic [1:0] CHG_DEC = 2'h1;
  // Unit size codes; 0x means 32 bits
  localparam logic [1:0] SIZE_16 = 2'h2;
  localparam logic [1:0] SIZE_8 = 2'h3;
  localparam logic [2:0] CSEL_MAX = 3'h4;
  localparam logic [AW-1:0] BYTES_32 = 32'h4;
  localparam logic [AW-1:0] BYTES_16 = 32'h2;
  localparam logic [AW-1:0] BYTES_8 = 32'h1;
  localparam logic [AW-1:0] WORD_RST = 32'h0;
endpackage

// ### dcra_hold_buf.sv
// Purpose: holding buffer for the word between source read and destination write
// Assumes: load is a one-cycle strobe
// Notes:   data comes straight from the register
`timescale 1ns/1ps
`default_nettype none

module dcra_hold_buf #(
  parameter int W = 32
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic load,
  input wire logic [W-1:0] load_data,
  output logic [W-1:0] data
);
  typedef struct packed {
    logic [W-1:0] word;
  } dcra_hb_t;

  dcra_hb_t s_reg;
  dcra_hb_t s_next;

  always_comb begin
    s_next = s_reg;
    if (load) begin
      s_next.word = load_data;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign data = s_reg.word;
endmodule // dcra_hold_buf

`default_nettype wire

// ### dcra_engine.sv
// Purpose: eight-channel engine: requests, bus arbitration with the core, transfers
// Assumes: all inputs except rst synchronous to mclk; bus answers each access with bus_done or bus_error
// Notes:   channel 0 has the highest fixed priority
`timescale 1ns/1ps
`default_nettype none

module dcra_engine (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [dcra_pkg::NCH-1:0][dcra_pkg::CCR_W-1:0] channel_control,
  input wire logic [dcra_pkg::NCH-1:0][dcra_pkg::DTCR_W-1:0] transfer_control,
  input wire logic [dcra_pkg::NCH-1:0][dcra_pkg::AW-1:0] src_addr_init,
  input wire logic [dcra_pkg::NCH-1:0][dcra_pkg::AW-1:0] dst_addr_init,
  input wire logic [dcra_pkg::NCH-1:0][dcra_pkg::AW-1:0] byte_count_init,
  input wire logic [dcra_pkg::NCH-1:0] start_pulse,
  input wire logic [dcra_pkg::NCH-1:0] chan_stop,
  input wire logic [dcra_pkg::NCH-1:0] irqctl_transfer_request_n,
  input wire logic [dcra_pkg::NCH-1:0] pin_transfer_request_n,
  input wire logic bus_grant,
  input wire logic core_release_req,
  input wire logic bus_done,
  input wire logic bus_error,
  input wire logic [dcra_pkg::AW-1:0] bus_rdata,
  output logic bus_req,
  output logic bus_snoop,
  output logic [dcra_pkg::AW-1:0] bus_addr,
  output logic [1:0] bus_size,
  output logic bus_rd,
  output logic bus_wr,
  output logic [dcra_pkg::AW-1:0] bus_wdata,
  output logic [dcra_pkg::NCH-1:0] transfer_ack_n,
  output logic nmi_hold,
  output logic [dcra_pkg::NCH-1:0] done_pulse,
  output logic [dcra_pkg::NCH-1:0] chan_active,
  output logic [dcra_pkg::NCH-1:0] chan_error
);
  import dcra_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ENG_IDLE,
    ENG_REQ,
    ENG_PICK,
    ENG_READ,
    ENG_WRITE
  } dcra_eng_t;

  typedef struct packed {
    dcra_eng_t eng;
    logic [NCH-1:0] active;
    logic [NCH-1:0] error;
    logic [NCH-1:0] edge_pend;
    logic [NCH-1:0] pin_prev;
    logic [NCH-1:0] ack_n;
    logic [NCH-1:0] done;
    logic [NCH-1:0][AW-1:0] src;
    logic [NCH-1:0][AW-1:0] dst;
    logic [NCH-1:0][AW-1:0] cnt;
    logic [2:0] cur;
    logic bus_req;
    logic snoop;
    logic rd;
    logic wr;
    logic nmi_hold;
    logic [AW-1:0] addr;
    logic [1:0] size;
  } dcra_state_t;

  dcra_state_t s_reg;
  dcra_state_t s_next;
  logic hb_load;
  logic [AW-1:0] hb_data;

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic [AW-1:0] unit_bytes(input logic [1:0] size);
    unique case (size)
      SIZE_16: unit_bytes = BYTES_16;
      SIZE_8: unit_bytes = BYTES_8;
      default: unit_bytes = BYTES_32;
    endcase
  endfunction

  // Code n selects counting from bit 4n, so the shift is {code, 2'b00}
  function automatic logic [AW-1:0] step_addr(input logic [AW-1:0] a,
                                              input logic [1:0] chg,
                                              input logic [2:0] csel,
                                              input logic [1:0] size);
    logic [AW-1:0] step;
    step = (csel == 3'h0) ? unit_bytes(size) : (BYTES_8 << {csel, 2'h0}); // see [RL19] [RL21]
    unique case (chg)
      CHG_INC: step_addr = a + step; // see [RL17]
      CHG_DEC: step_addr = a - step;
      default: step_addr = a;
    endcase
  endfunction

  function automatic logic [2:0] pick_chan(input logic [NCH-1:0] req);
    pick_chan = 3'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (req[i]) begin
        pick_chan = 3'(i);
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Request detection
  // ----------------------------------------------------------------
  logic [NCH-1:0] m2m;
  logic [NCH-1:0] ext_req;
  logic [NCH-1:0] pending;
  logic [NCH-1:0] fall;
  logic [2:0] pick;
  logic any_pending;

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      m2m[c] = ~channel_control[c][CCR_SRC_IO] & ~channel_control[c][CCR_DST_IO];
      fall[c] = s_reg.pin_prev[c] & ~pin_transfer_request_n[c];
      // Pin detection is tied to the device mix rather than a separate switch
      ext_req[c] = ~irqctl_transfer_request_n[c] // see [RL11]
                   | (m2m[c] ? ~pin_transfer_request_n[c] : s_reg.edge_pend[c]); // see [RL24]
      // Internal requests stay up until the channel ends
      pending[c] = s_reg.active[c]
                   & (channel_control[c][CCR_EXT] ? ext_req[c] : 1'b1); // see [RL7] [RL8] [RL10]
    end
    any_pending = |pending;
    pick = pick_chan(pending);
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  logic [CCR_W-1:0] cc;
  logic [DTCR_W-1:0] tc;
  logic [AW-1:0] ub;
  logic last;
  logic yield_now;
  logic bad_cfg;

  always_comb begin
    s_next = s_reg;
    hb_load = 1'b0;
    s_next.done = '0;
    s_next.pin_prev = pin_transfer_request_n;
    cc = channel_control[s_reg.cur];
    tc = transfer_control[s_reg.cur];
    ub = unit_bytes(cc[CCR_SIZE_LO +: 2]);
    last = (s_reg.cnt[s_reg.cur] <= ub);
    // A core release request only counts in non-snoop mode
    yield_now = core_release_req & ~cc[CCR_SNOOP] & cc[CCR_YIELD]; // see [RL3]
    bad_cfg = 1'b0;

    unique case (s_reg.eng)
      ENG_IDLE: begin
        if (any_pending) begin
          s_next.bus_req = 1'b1; // see [RL1]
          s_next.snoop = channel_control[pick][CCR_SNOOP]; // see [RL2]
          s_next.eng = ENG_REQ;
        end
      end
      ENG_REQ: begin
        if (!any_pending) begin
          s_next.bus_req = 1'b0;
          s_next.eng = ENG_IDLE;
        end else if (bus_grant) begin
          s_next.nmi_hold = 1'b1; // see [RL5]
          s_next.eng = ENG_PICK;
        end
      end
      ENG_PICK: begin
        s_next.ack_n = '1;
        if (!any_pending || yield_now) begin
          s_next.bus_req = 1'b0; // see [RL4] [RL15]
          s_next.nmi_hold = 1'b0;
          s_next.eng = ENG_IDLE;
        end else begin
          // Bus cycles only start once the grant has been seen
          s_next.cur = pick; // see [RL1] [RL8]
          s_next.addr = s_reg.src[pick];
          s_next.size = channel_control[pick][CCR_SIZE_LO +: 2]; // see [RL20]
          s_next.rd = 1'b1; // see [RL12]
          s_next.ack_n[pick] = ~channel_control[pick][CCR_SRC_IO]; // see [RL13]
          s_next.eng = ENG_READ;
        end
      end
      ENG_READ: begin
        if (bus_error) begin
          s_next.rd = 1'b0;
          s_next.ack_n = '1;
          s_next.active[s_reg.cur] = 1'b0; // see [RL15]
          s_next.error[s_reg.cur] = 1'b1;
          s_next.eng = ENG_PICK;
        end else if (bus_done) begin
          hb_load = 1'b1; // see [RL12]
          s_next.rd = 1'b0;
          s_next.wr = 1'b1;
          s_next.addr = s_reg.dst[s_reg.cur];
          s_next.ack_n = '1;
          s_next.ack_n[s_reg.cur] = ~cc[CCR_DST_IO]; // see [RL13]
          s_next.eng = ENG_WRITE;
        end
      end
      ENG_WRITE: begin
        if (bus_error) begin
          s_next.wr = 1'b0;
          s_next.ack_n = '1;
          s_next.active[s_reg.cur] = 1'b0; // see [RL15]
          s_next.error[s_reg.cur] = 1'b1;
          s_next.eng = ENG_PICK;
        end else if (bus_done) begin
          s_next.wr = 1'b0;
          s_next.ack_n = '1;
          s_next.edge_pend[s_reg.cur] = 1'b0;
          s_next.src[s_reg.cur] = step_addr(s_reg.src[s_reg.cur], cc[CCR_SAC_LO +: 2],
                                            tc[DTCR_SOURCE_COUNT_BIT_SEL_LO +: 3], cc[CCR_SIZE_LO +: 2]);
          s_next.dst[s_reg.cur] = step_addr(s_reg.dst[s_reg.cur], cc[CCR_DAC_LO +: 2],
                                            tc[DTCR_DEST_COUNT_BIT_SEL_LO +: 3], cc[CCR_SIZE_LO +: 2]);
          s_next.cnt[s_reg.cur] = last ? WORD_RST : s_reg.cnt[s_reg.cur] - ub;
          if (last) begin
            s_next.active[s_reg.cur] = 1'b0; // see [RL15]
            s_next.done[s_reg.cur] = 1'b1; // see [RL16]
            // Memory-to-memory: the strobe that clears the router comes only now
            if (m2m[s_reg.cur] && cc[CCR_EXT]) begin
              s_next.ack_n[s_reg.cur] = 1'b0; // see [RL23]
            end
          end
          s_next.eng = ENG_PICK;
        end
      end
    endcase

    // Channel control after the engine, so a new edge outlives its clear
    for (int c = 0; c < NCH; c++) begin
      if (s_reg.active[c] && fall[c]) begin
        s_next.edge_pend[c] = 1'b1; // see [RL11]
      end
      if (chan_stop[c]) begin
        s_next.active[c] = 1'b0;
      end
      if (start_pulse[c] && !s_reg.active[c]) begin
        bad_cfg = (transfer_control[c][DTCR_SOURCE_COUNT_BIT_SEL_LO +: 3] > CSEL_MAX) // see [RL22]
                  | (transfer_control[c][DTCR_DEST_COUNT_BIT_SEL_LO +: 3] > CSEL_MAX)
                  | (~channel_control[c][CCR_EXT] & ~m2m[c]); // see [RL9]
        s_next.error[c] = bad_cfg;
        s_next.active[c] = ~bad_cfg; // see [RL14]
        s_next.edge_pend[c] = 1'b0;
        s_next.src[c] = src_addr_init[c];
        s_next.dst[c] = dst_addr_init[c];
        s_next.cnt[c] = byte_count_init[c];
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_reg <= '{eng: ENG_IDLE, ack_n: '1, pin_prev: '1, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  dcra_hold_buf #(
    .W(AW)
  ) u_hold (
    .mclk(mclk),
    .rst(rst),
    .load(hb_load),
    .load_data(bus_rdata),
    .data(hb_data)
  );

  assign bus_req = s_reg.bus_req;
  assign bus_snoop = s_reg.snoop;
  assign bus_addr = s_reg.addr;
  assign bus_size = s_reg.size;
  assign bus_rd = s_reg.rd;
  assign bus_wr = s_reg.wr;
  assign bus_wdata = hb_data;
  assign transfer_ack_n = s_reg.ack_n;
  assign nmi_hold = s_reg.nmi_hold;
  assign done_pulse = s_reg.done;
  assign chan_active = s_reg.active;
  assign chan_error = s_reg.error;
endmodule // dcra_engine

`default_nettype wire

// ### dcra_properties.sv
// Purpose: port-level checks of the transfer engine
// Assumes: one mclk domain, rst asynchronous and active high
// Notes: bound to the engine from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module dcra_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [dcra_pkg::NCH-1:0][dcra_pkg::CCR_W-1:0] channel_control,
  input wire logic [dcra_pkg::NCH-1:0][dcra_pkg::DTCR_W-1:0] transfer_control,
  input wire logic [dcra_pkg::NCH-1:0] start_pulse,
  input wire logic bus_grant,
  input wire logic bus_done,
  input wire logic bus_error,
  input wire logic [dcra_pkg::AW-1:0] bus_rdata,
  input wire logic bus_req,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [dcra_pkg::AW-1:0] bus_wdata,
  input wire logic nmi_hold,
  input wire logic [dcra_pkg::NCH-1:0] done_pulse,
  input wire logic [dcra_pkg::NCH-1:0] chan_active,
  input wire logic [dcra_pkg::NCH-1:0] chan_error
);
  import dcra_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_grant_before_own: assert property ($rose(nmi_hold) |-> $past(bus_grant && bus_req))
    else $error("bus owned without grant");
  a_cycle_while_own: assert property ((bus_rd || bus_wr) |-> nmi_hold && bus_grant)
    else $error("access outside ownership");
  a_nmi_released: assert property ($fell(bus_req) |-> !nmi_hold)
    else $error("nmi still held after release");
  a_write_follows: assert property ($past(bus_rd && bus_done) |-> bus_wr && !bus_rd)
    else $error("no write after read");
  a_buffer_data: assert property ($past(bus_rd && bus_done) |-> bus_wdata == $past(bus_rdata))
    else $error("write data differs from read");
  a_rd_wr_apart: assert property (!(bus_rd && bus_wr))
    else $error("read and write together");
  a_done_cause: assert property ((|done_pulse) |-> $past(bus_done || bus_error))
    else $error("completion without access end");
  a_bus_release: assert property ($fell(|chan_active) |-> ##[1:3] !bus_req)
    else $error("bus kept with nothing pending");
  a_start_internal: assert property ((start_pulse[0] && !chan_active[0]
      && !channel_control[0][CCR_EXT] && channel_control[0][1:0] == 2'h0
      && transfer_control[0][2:0] <= CSEL_MAX && transfer_control[0][5:3] <= CSEL_MAX)
      |=> chan_active[0] ##1 bus_req)
    else $error("internal start raised no request");
  a_bad_select: assert property ((start_pulse[0] && !chan_active[0]
      && transfer_control[0][5:3] > CSEL_MAX) |=> chan_error[0] && !chan_active[0])
    else $error("prohibited count select accepted");
endmodule // dcra_properties
`default_nettype wire

// ### dcra_bus_model.sv
// Purpose: core-side arbiter and memory responder for the engine
// Assumes: one access answered at a time
// Notes: slow adds wait cycles, fail turns the answer into an error
`timescale 1ns/1ps
`default_nettype none
module dcra_bus_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic bus_req,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [dcra_pkg::AW-1:0] bus_addr,
  input wire logic [1:0] slow,
  input wire logic fail,
  output logic bus_grant,
  output logic bus_done,
  output logic bus_error,
  output logic [dcra_pkg::AW-1:0] bus_rdata
);
  import dcra_pkg::*;
  logic [1:0] wait_reg;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus_grant <= 1'b0;
      bus_done <= 1'b0;
      bus_error <= 1'b0;
      bus_rdata <= WORD_RST;
      wait_reg <= 2'h0;
    end else begin
      // Core is never halted, so every request is granted a cycle later
      bus_grant <= bus_req;
      bus_done <= 1'b0;
      bus_error <= 1'b0;
      // Data lines toggle when idle so a stale word cannot pass as good
      bus_rdata <= ~bus_rdata;
      if ((bus_rd || bus_wr) && !bus_done && !bus_error) begin
        if (wait_reg == slow) begin
          wait_reg <= 2'h0;
          bus_done <= !fail;
          bus_error <= fail;
          if (bus_rd) bus_rdata <= bus_addr ^ 32'h5a5a_0000;
        end else begin
          wait_reg <= wait_reg + 2'h1;
        end
      end
    end
  end
endmodule // dcra_bus_model
`default_nettype wire

// ### dcra_engine_test.sv
// Purpose: self-checking bench for the transfer engine
// Assumes: partner model answers reads with address-derived data
// Notes: driver queues expected traffic, a monitor pops it per access
`timescale 1ns/1ps
`default_nettype none
module dcra_engine_test;
  import dcra_pkg::*;
  logic mclk, rst, grant, done, berr, fail, req, snoop, rd, wr, nmi;
  logic [1:0] size, slow;
  logic [AW-1:0] rdata, addr, wdata;
  logic [NCH-1:0][CCR_W-1:0] cc;
  logic [NCH-1:0][DTCR_W-1:0] tc;
  logic [NCH-1:0][AW-1:0] sa, da, bc;
  logic [NCH-1:0] sp, irq_n, ack_n, dp, act, err;
  logic [31:0] q[$];
  int error_cnt, comparisons, seed, k;
  dcra_engine dcra_engine_i (.mclk(mclk), .rst(rst), .channel_control(cc),
    .transfer_control(tc), .src_addr_init(sa), .dst_addr_init(da), .byte_count_init(bc),
    .start_pulse(sp), .chan_stop({NCH{1'b0}}), .irqctl_transfer_request_n(irq_n),
    .pin_transfer_request_n({NCH{1'b1}}), .bus_grant(grant), .core_release_req(1'b0),
    .bus_done(done), .bus_error(berr), .bus_rdata(rdata), .bus_req(req), .bus_snoop(snoop),
    .bus_addr(addr), .bus_size(size), .bus_rd(rd), .bus_wr(wr), .bus_wdata(wdata),
    .transfer_ack_n(ack_n), .nmi_hold(nmi), .done_pulse(dp), .chan_active(act),
    .chan_error(err));
  dcra_bus_model dcra_bus_model_i (.mclk(mclk), .rst(rst), .bus_req(req), .bus_rd(rd),
    .bus_wr(wr), .bus_addr(addr), .slow(slow), .fail(fail), .bus_grant(grant),
    .bus_done(done), .bus_error(berr), .bus_rdata(rdata));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [31:0] nxt(input logic [31:0] a, input logic [1:0] chg,
      input logic [2:0] cs, input logic [1:0] sz);
    logic [31:0] st;
    st = (cs != 3'h0) ? (32'h1 << (4 * cs)) : (sz == SIZE_8) ? BYTES_8 :
      (sz == SIZE_16) ? BYTES_16 : BYTES_32;
    return (chg == CHG_INC) ? a + st : (chg == CHG_DEC) ? a - st : a;
  endfunction
  // Per unit: source, read ack, destination, data, write ack
  always @(negedge mclk) begin
    if (done && q.size() > 2) begin
      check(addr, q.pop_front());
      if (wr) check(wdata, q.pop_front());
      check({24'h0, ack_n}, q.pop_front());
    end else if (done) check(32'h1, 32'h0);
  end
  task automatic run(input int ch, input logic [15:0] c, input logic [5:0] t,
      input logic [31:0] n);
    logic [31:0] s, d, u;
    int i;
    s = $random(seed) & 32'hffff_fffc;
    d = $random(seed) & 32'hffff_fffc;
    u = nxt(32'h0, CHG_INC, 3'h0, c[3:2]);
    for (i = 0; i < n / u; i++) begin
      q.push_back(s);
      q.push_back(c[CCR_SRC_IO] ? ~(32'h1 << ch) & 32'hff : 32'hff);
      q.push_back(d);
      q.push_back(s ^ 32'h5a5a_0000);
      q.push_back(c[CCR_DST_IO] ? ~(32'h1 << ch) & 32'hff : 32'hff);
      s = nxt(s, c[7:6], t[2:0], c[3:2]);
      d = nxt(d, c[5:4], t[5:3], c[3:2]);
    end
    @(negedge mclk);
    cc[ch] = c;
    tc[ch] = t;
    sa[ch] = q[0];
    da[ch] = q[2];
    bc[ch] = n;
    slow = $random(seed);
    sp[ch] = 1'b1;
    @(negedge mclk);
    sp[ch] = 1'b0;
    if (c[CCR_EXT]) begin
      repeat (8) @(negedge mclk);
      check(req, 1'b0);
      irq_n[ch] = 1'b0;
    end
    i = 0;
    while (!dp[ch] && i < 400) begin
      @(negedge mclk);
      i++;
    end
    irq_n[ch] = 1'b1;
    check(dp[ch], 1'b1);
    check({29'h0, snoop, size}, {29'h0, c[CCR_SNOOP], c[3:2]});
    check(32'(q.size()), 32'h0);
    $display("test on channel %0d done", ch);
  endtask
  task automatic bad(input int ch, input logic [15:0] c, input logic [5:0] t);
    @(negedge mclk);
    cc[ch] = c;
    tc[ch] = t;
    sp[ch] = 1'b1;
    @(negedge mclk);
    sp[ch] = 1'b0;
    check({act[ch], err[ch]}, 32'h1);
  endtask
  initial begin
    seed = 91;
    error_cnt = 0;
    comparisons = 0;
    {rst, fail, slow, cc, tc, sa, da, bc, sp} = '0;
    rst = 1'b1;
    irq_n = '1;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    run(0, 16'h0800, 6'h08, 32'hc);
    run(1, 16'h0458, 6'h02, 32'h8);
    run(7, 16'h008c, 6'h00, 32'h3);
    run(3, 16'h0221, 6'h00, 32'h4);
    run(2, 16'h0282, 6'h00, 32'h4);
    run(4, 16'h0200, 6'h24, 32'h8);
    bad(0, 16'h0000, 6'h28);
    bad(6, 16'h0021, 6'h00);
    fail = 1'b1;
    // A valid start on a failing bus: active first, then ended with an error
    @(negedge mclk);
    cc[5] = 16'h0000;
    tc[5] = 6'h00;
    sp[5] = 1'b1;
    @(negedge mclk);
    sp[5] = 1'b0;
    check({act[5], err[5]}, 32'h2);
    k = 0;
    while (act[5] && k < 100) begin
      @(negedge mclk);
      k++;
    end
    check({act[5], err[5]}, 32'h1);
    stop_test;
  end
  initial begin
    #250000;
    error_cnt++;
    stop_test;
  end
endmodule // dcra_engine_test
bind dcra_engine dcra_properties dcra_properties_i (.mclk(mclk), .rst(rst),
  .channel_control(channel_control), .transfer_control(transfer_control),
  .start_pulse(start_pulse), .bus_grant(bus_grant), .bus_done(bus_done),
  .bus_error(bus_error), .bus_rdata(bus_rdata), .bus_req(bus_req), .bus_rd(bus_rd),
  .bus_wr(bus_wr), .bus_wdata(bus_wdata), .nmi_hold(nmi_hold), .done_pulse(done_pulse),
  .chan_active(chan_active), .chan_error(chan_error));
`default_nettype wire
